/* rxsw_pkg.sv */
// rxsw_pkg: constants for the receive status word and receiver control block
package rxsw_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_MAC_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_RX_STATE   = 8'h04;
    localparam logic [7:0]  OFS_STS_POP    = 8'h08;
    localparam logic [7:0]  OFS_DATA_POP   = 8'h0C;
    // mac_control_reg fields
    localparam int          CTL_RXON_BIT   = 2;
    localparam int          CTL_PASSBAD    = 16;
    localparam logic [31:0] CTL_RESET      = 32'h0000_0000;
    // rx state register fields
    localparam int          ST_RXERR_BIT   = 0;
    localparam int          ST_RUN_BIT     = 1;
    localparam int          ST_SCNT_LSB    = 8;
    // status word fields
    localparam int          SW_ES          = 15;
    localparam int          SW_RUNT        = 11;
    localparam int          SW_MCAST       = 10;
    localparam int          SW_LONG        = 7;
    localparam int          SW_LATECOL     = 6;
    localparam int          SW_FTYPE       = 5;
    localparam int          SW_WDOG        = 4;
    localparam int          SW_MIIERR      = 3;
    localparam int          SW_DRIBBLE     = 2;
    localparam int          SW_CRC         = 1;
    localparam int          SW_LEN_LSB     = 16;
    // frame size limits in bytes
    localparam logic [13:0] COLL_WINDOW    = 14'd64;
    localparam logic [13:0] MAX_FRAME      = 14'd1518;
    localparam logic [15:0] MAX_LENTYPE    = 16'd1500;
    localparam logic [13:0] HDR_BYTES      = 14'd14;
    localparam logic [13:0] WDOG_LIMIT     = 14'd2048;
    // dribble thresholds
    localparam logic [2:0]  DRIB_MII       = 3'd4;
    localparam logic [2:0]  DRIB_10M       = 3'd3;
    // crc
    localparam logic [31:0] CRC_INIT       = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY_R     = 32'hEDB8_8320;
    localparam logic [31:0] CRC_RESIDUE    = 32'hDEBB_20E3;
    // fifo geometry
    localparam int          DAW            = 6;
    localparam int          SAW            = 3;
    // receive sequencer
    typedef enum logic [1:0] {
        RX_IDLE   = 2'b00,
        RX_RECV   = 2'b01,
        RX_FLUSH  = 2'b10,
        RX_STATUS = 2'b11
    } rxsw_state_t;
endpackage

/* rxsw_top.sv */
// rxsw_top: receive status word builder, rx fifos and receiver stop/start control
// Behaviour
// - runt bit when frame under 64 bytes
// - runts kept only with pass-bad-frames set
// - multicast bit from destination group bit
// - status bits 9:8 and 0 zero
// - too-long bit over 1518, no truncation
// - late collision bit after collision window
// - frame type bit, never for short runts
// - watchdog bit when frame passes limit
// - interface error bit on any rx_er
// - dribble bit for 4 bits, or >=3 in 10M mode
// - no dribble bit with late collision
// - dribble with good crc is valid frame
// - crc bit on mismatch or rx_er
// - one halted pulse once receiver stops
// - error flag never stops reception
// - error flag on underruns or status overrun
// - error summary is or of bad bits
// - byte count in bits 29:16
// - status pushed after all frame data
`timescale 1ns/1ps
module rxsw_top
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // byte stream from the mac frame path
    input  wire logic        rx_frame,
    input  wire logic        rx_byte_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_err,
    input  wire logic        rx_col,
    input  wire logic [2:0]  rx_dribble_bits,
    input  wire logic        rx_mode_10m,
    // events
    output logic             receiver_halted_irq
);

    // control and flag registers
    logic [31:0]             mac_control_reg;     // software control word
    logic                    receiver_error_flag; // sticky, write one to clear
    logic                    rx_running;          // receiver currently accepting frames
    rxsw_pkg::rxsw_state_t   state;
    logic                    rx_frame_q;          // rx_frame one cycle back, for start edge

    // data fifo storage and pointers
    logic [31:0]             dmem [0:(1<<rxsw_pkg::DAW)-1];
    logic [rxsw_pkg::DAW:0]  d_wr;                // tentative write pointer
    logic [rxsw_pkg::DAW:0]  d_commit;            // end of last accepted frame
    logic [rxsw_pkg::DAW:0]  d_rd;
    // status fifo storage and pointers
    logic [31:0]             smem [0:(1<<rxsw_pkg::SAW)-1];
    logic [rxsw_pkg::SAW:0]  s_wr;
    logic [rxsw_pkg::SAW:0]  s_rd;

    // frame accumulation
    logic [13:0]             byte_cnt;            // bytes seen in this frame
    logic [31:0]             pack;                // word being assembled
    logic [1:0]              lane;                // next byte lane
    logic [31:0]             crc;
    logic [15:0]             lentype;
    logic                    f_mcast;
    logic                    f_latecol;
    logic                    f_wdog;
    logic                    f_miierr;
    logic                    f_dribble;
    logic [31:0]             sword;               // finished status word
    logic                    frame_ok;            // frame is to be kept

    // apb helpers
    logic                    setup;
    logic                    access;
    logic                    sts_empty_q;         // status fifo empty seen at setup
    logic                    dat_empty_q;         // data fifo empty seen at setup

    // fifo state
    logic                    d_full;
    logic                    d_empty;
    logic                    s_full;
    logic                    s_empty;
    logic                    push_word;
    logic [31:0]             push_data;
    logic                    frame_end;
    logic                    stop_done;

    // crc over one byte, reflected
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h00_0000, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ rxsw_pkg::CRC_POLY_R) : (r >> 1);
        end
        return r;
    endfunction

    assign setup    = psel & ~penable;
    assign access   = psel & penable & pready;
    assign d_full   = (d_wr[rxsw_pkg::DAW] != d_rd[rxsw_pkg::DAW]) &&
                      (d_wr[rxsw_pkg::DAW-1:0] == d_rd[rxsw_pkg::DAW-1:0]);
    assign d_empty  = (d_rd == d_commit);
    assign s_full   = (s_wr[rxsw_pkg::SAW] != s_rd[rxsw_pkg::SAW]) &&
                      (s_wr[rxsw_pkg::SAW-1:0] == s_rd[rxsw_pkg::SAW-1:0]);
    assign s_empty  = (s_wr == s_rd);
    assign frame_end = (state == rxsw_pkg::RX_RECV) && !rx_frame;

    // status word assembly from the per-frame flags
    always_comb
    begin
        sword = 32'h0000_0000;
        sword[29:rxsw_pkg::SW_LEN_LSB] = byte_cnt;
        sword[rxsw_pkg::SW_RUNT]    = byte_cnt < rxsw_pkg::COLL_WINDOW;
        sword[rxsw_pkg::SW_MCAST]   = f_mcast;
        sword[rxsw_pkg::SW_LONG]    = byte_cnt > rxsw_pkg::MAX_FRAME;
        sword[rxsw_pkg::SW_LATECOL] = f_latecol;
        sword[rxsw_pkg::SW_FTYPE]   = (byte_cnt >= rxsw_pkg::HDR_BYTES) &&
                                      (lentype > rxsw_pkg::MAX_LENTYPE);
        sword[rxsw_pkg::SW_WDOG]    = f_wdog;
        sword[rxsw_pkg::SW_MIIERR]  = f_miierr;
        sword[rxsw_pkg::SW_DRIBBLE] = f_dribble & ~f_latecol;
        sword[rxsw_pkg::SW_CRC]     = (crc != rxsw_pkg::CRC_RESIDUE) | f_miierr;
        sword[rxsw_pkg::SW_ES]      = sword[rxsw_pkg::SW_RUNT] | sword[rxsw_pkg::SW_LONG] |
                                      sword[rxsw_pkg::SW_LATECOL] | sword[rxsw_pkg::SW_CRC];
        sword[9:8] = 2'b00;
        sword[0]   = 1'b0;
    end

    // runts dropped unless pass-bad-frames is set
    // dribble alone never makes a frame bad
    assign frame_ok = !sword[rxsw_pkg::SW_RUNT] || mac_control_reg[rxsw_pkg::CTL_PASSBAD];

    // word packer: a full word or the final partial word goes to the data fifo
    always_comb
    begin
        push_word = 1'b0;
        push_data = pack;
        if (state == rxsw_pkg::RX_RECV && rx_frame && rx_byte_valid &&
            byte_cnt < rxsw_pkg::WDOG_LIMIT && lane == 2'd3)
        begin
            push_word = 1'b1;
            push_data = {rx_byte, pack[23:0]};
        end
        else if (state == rxsw_pkg::RX_FLUSH && lane != 2'd0)
        begin
            push_word = 1'b1;
        end
    end

    // receive sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state      <= rxsw_pkg::RX_IDLE;
            rx_frame_q <= 1'b0;
        end
        else
        begin
            // edge memory so a frame already running at enable is skipped whole
            rx_frame_q <= rx_frame;
            case (state)
                rxsw_pkg::RX_IDLE:
                begin
                    // frames start only while enabled; mid-frame enables wait
                    if (rx_frame && !rx_frame_q && rx_running &&
                        mac_control_reg[rxsw_pkg::CTL_RXON_BIT])
                    begin
                        state <= rxsw_pkg::RX_RECV;
                    end
                end
                rxsw_pkg::RX_RECV:
                begin
                    if (!rx_frame)
                    begin
                        state <= rxsw_pkg::RX_FLUSH;
                    end
                end
                rxsw_pkg::RX_FLUSH:
                begin
                    state <= rxsw_pkg::RX_STATUS;
                end
                rxsw_pkg::RX_STATUS:
                begin
                    state <= rxsw_pkg::RX_IDLE;
                end
                default:
                begin
                    state <= rxsw_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // per-frame accumulation of bytes, crc and flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            byte_cnt  <= 14'd0;
            pack      <= 32'h0000_0000;
            lane      <= 2'd0;
            crc       <= rxsw_pkg::CRC_INIT;
            lentype   <= 16'h0000;
            f_mcast   <= 1'b0;
            f_latecol <= 1'b0;
            f_wdog    <= 1'b0;
            f_miierr  <= 1'b0;
            f_dribble <= 1'b0;
        end
        else if (state == rxsw_pkg::RX_IDLE)
        begin
            // clear for the next frame
            byte_cnt  <= 14'd0;
            pack      <= 32'h0000_0000;
            lane      <= 2'd0;
            crc       <= rxsw_pkg::CRC_INIT;
            lentype   <= 16'h0000;
            f_mcast   <= 1'b0;
            f_latecol <= 1'b0;
            f_wdog    <= 1'b0;
            f_miierr  <= 1'b0;
            f_dribble <= 1'b0;
        end
        else if (state == rxsw_pkg::RX_RECV && rx_frame)
        begin
            if (rx_err)
            begin
                f_miierr <= 1'b1;
            end
            if (rx_col && byte_cnt >= rxsw_pkg::COLL_WINDOW)
            begin
                f_latecol <= 1'b1;
            end
            if (rx_byte_valid)
            begin
                // counting goes on past 1518, nothing is cut there
                byte_cnt <= byte_cnt + 14'd1;
                crc      <= crc_byte(crc, rx_byte);
                // past the limit bytes are counted, not stored
                if (byte_cnt >= rxsw_pkg::WDOG_LIMIT)
                begin
                    f_wdog <= 1'b1;
                end
                else
                begin
                    lane <= lane + 2'd1;
                    pack <= (lane == 2'd3) ? 32'h0000_0000 : (pack | ({24'h00_0000, rx_byte}
                            << {lane, 3'b000}));
                end
                // group bit of first destination byte
                if (byte_cnt == 14'd0)
                begin
                    f_mcast <= rx_byte[0];
                end
                if (byte_cnt == 14'd12)
                begin
                    lentype[15:8] <= rx_byte;
                end
                if (byte_cnt == 14'd13)
                begin
                    lentype[7:0] <= rx_byte;
                end
            end
        end
        else if (frame_end)
        begin
            f_dribble <= rx_mode_10m ? (rx_dribble_bits >= rxsw_pkg::DRIB_10M)
                                     : (rx_dribble_bits == rxsw_pkg::DRIB_MII);
        end
    end

    // data fifo write side with commit or rewind per frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            d_wr     <= '0;
            d_commit <= '0;
        end
        else
        begin
            // full fifo drops the word; the host sees it in the length only
            if (push_word && !d_full)
            begin
                d_wr <= d_wr + 1'b1;
            end
            if (state == rxsw_pkg::RX_STATUS)
            begin
                // data committed with the status push
                if (frame_ok && !s_full)
                begin
                    d_commit <= d_wr;
                end
                else
                begin
                    d_wr <= d_commit;
                end
            end
        end
    end

    // data fifo array
    always_ff @(posedge pclk)
    begin
        if (push_word && !d_full)
        begin
            dmem[d_wr[rxsw_pkg::DAW-1:0]] <= push_data;
        end
    end

    // status fifo write, one state after the flush state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_wr <= '0;
        end
        else if (state == rxsw_pkg::RX_STATUS && frame_ok && !s_full)
        begin
            s_wr <= s_wr + 1'b1;
        end
    end

    always_ff @(posedge pclk)
    begin
        if (state == rxsw_pkg::RX_STATUS && frame_ok && !s_full)
        begin
            smem[s_wr[rxsw_pkg::SAW-1:0]] <= sword;
        end
    end

    // read pointers advance on completed pops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_rd <= '0;
            d_rd <= '0;
        end
        else if (access && !pwrite)
        begin
            if (paddr == rxsw_pkg::OFS_STS_POP && !sts_empty_q)
            begin
                s_rd <= s_rd + 1'b1;
            end
            if (paddr == rxsw_pkg::OFS_DATA_POP && !dat_empty_q)
            begin
                d_rd <= d_rd + 1'b1;
            end
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mac_control_reg <= rxsw_pkg::CTL_RESET;
        end
        // host clears or sets the receiver on bit here
        else if (access && pwrite && paddr == rxsw_pkg::OFS_MAC_CTRL)
        begin
            mac_control_reg <= pwdata;
        end
    end

    assign stop_done = rx_running && !mac_control_reg[rxsw_pkg::CTL_RXON_BIT] &&
                       (state == rxsw_pkg::RX_IDLE);

    // run state and halt pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_running          <= 1'b0;
            receiver_halted_irq <= 1'b0;
        end
        else
        begin
            receiver_halted_irq <= 1'b0;
            if (mac_control_reg[rxsw_pkg::CTL_RXON_BIT])
            begin
                rx_running <= 1'b1;
            end
            // halt waits for the frame and its status
            else if (stop_done)
            begin
                rx_running <= 1'b0;
                receiver_halted_irq <= 1'b1;
            end
        end
    end

    // receiver error flag; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            receiver_error_flag <= 1'b0;
        end
        // underrun of either fifo or status overrun
        else if ((access && !pwrite && paddr == rxsw_pkg::OFS_STS_POP && sts_empty_q) ||
                 (access && !pwrite && paddr == rxsw_pkg::OFS_DATA_POP && dat_empty_q) ||
                 (state == rxsw_pkg::RX_STATUS && frame_ok && s_full))
        begin
            receiver_error_flag <= 1'b1;
        end
        else if (access && pwrite && paddr == rxsw_pkg::OFS_RX_STATE &&
                 pwdata[rxsw_pkg::ST_RXERR_BIT])
        begin
            receiver_error_flag <= 1'b0;
        end
    end

    // apb answer: data latched in setup, ready in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            sts_empty_q <= 1'b1;
            dat_empty_q <= 1'b1;
        end
        else
        begin
            pready  <= setup;
            pslverr <= 1'b0;
            if (setup)
            begin
                sts_empty_q <= s_empty;
                dat_empty_q <= d_empty;
                prdata      <= 32'h0000_0000;
                case (paddr)
                    rxsw_pkg::OFS_MAC_CTRL:
                    begin
                        prdata <= mac_control_reg;
                    end
                    rxsw_pkg::OFS_RX_STATE:
                    begin
                        prdata[rxsw_pkg::ST_RXERR_BIT] <= receiver_error_flag;
                        prdata[rxsw_pkg::ST_RUN_BIT]   <= rx_running;
                        prdata[rxsw_pkg::ST_SCNT_LSB +: rxsw_pkg::SAW+1] <= s_wr - s_rd;
                    end
                    rxsw_pkg::OFS_STS_POP:
                    begin
                        // empty pop reads zero and flags underrun
                        prdata <= s_empty ? 32'h0000_0000 : smem[s_rd[rxsw_pkg::SAW-1:0]];
                    end
                    rxsw_pkg::OFS_DATA_POP:
                    begin
                        prdata <= d_empty ? 32'h0000_0000 : dmem[d_rd[rxsw_pkg::DAW-1:0]];
                    end
                    default:
                    begin
                        // unmapped address answers with an error
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // rxsw_top

/* rxsw_monitor.sv */
// rxsw_monitor: status word and halt pulse checks at rxsw_top ports
`timescale 1ns/1ps
module rxsw_monitor
(
    // clock, reset and apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // events
    input wire logic        receiver_halted_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // answered status pop; underrun answers read zero, so pop skips them
    wire        rd  = pready && !pwrite && paddr == 8'h08;
    wire        pop = rd && prdata != 32'h0;
    wire [13:0] len = prdata[29:16];
    property p_zero; rd |-> prdata[9:8] == 2'b00 && !prdata[0]; endproperty
    property p_es; pop |-> prdata[15] == |{prdata[11], prdata[7], prdata[6], prdata[1]}; endproperty
    property p_runt; pop |-> prdata[11] == (len < 14'd64); endproperty
    property p_long; pop |-> prdata[7] == (len > 14'd1518); endproperty
    property p_ftype; pop && len < 14'd14 |-> !prdata[5]; endproperty
    property p_wdog; pop && prdata[4] |-> len > 14'd2048; endproperty
    property p_drib; pop && prdata[6] |-> !prdata[2]; endproperty
    property p_irq; receiver_halted_irq |=> !receiver_halted_irq [*8]; endproperty
    a_zero: assert property (p_zero) else $error("reserved bits set");
    a_es: assert property (p_es) else $error("summary bit wrong");
    a_runt: assert property (p_runt) else $error("runt bit wrong");
    a_long: assert property (p_long) else $error("too long bit wrong");
    a_ftype: assert property (p_ftype) else $error("type bit on short runt");
    a_wdog: assert property (p_wdog) else $error("watchdog bit early");
    a_drib: assert property (p_drib) else $error("dribble with collision");
    a_irq: assert property (p_irq) else $error("halt pulse too long");
    // main scenarios reached
    c_runt: cover property (pop && prdata[11]);
    c_wdog: cover property (pop && prdata[4]);
    c_irq: cover property (receiver_halted_irq);
endmodule // rxsw_monitor

bind rxsw_top rxsw_monitor u_mon (.pclk, .presetn, .pwrite, .paddr, .prdata, .pready,
    .receiver_halted_irq);

/* rxsw_frame_src.sv */
// rxsw_frame_src: byte stream model of the mac frame path
`timescale 1ns/1ps
module rxsw_frame_src
(
    // clock
    input  wire logic  pclk,
    // frame path pins
    output logic       rx_frame = 1'b0,
    output logic       rx_byte_valid = 1'b0,
    output logic [7:0] rx_byte = 8'h5A,
    output logic       rx_err = 1'b0,
    output logic       rx_col = 1'b0,
    output logic [2:0] rx_dribble_bits = 3'h0,
    output logic       rx_mode_10m = 1'b0
);
    integer     seed = 32'h6D6E;  // fixed seed for payload bytes
    logic [7:0] fb [0:3];         // first bytes, kept for the bench
    // one frame, a byte every other cycle, good fcs unless bad
    task automatic send(input int n, input logic mc, input logic [15:0] lt, input logic er,
                        input int ca, input logic [2:0] db, input logic m10, input logic bad);
        logic [31:0] c;
        logic [31:0] f;
        logic [7:0]  b;
        c = 32'hFFFF_FFFF;
        f = 32'h0;
        @(posedge pclk);
        rx_frame <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            b = 8'($random(seed));
            b[0] = (i == 0) ? mc : b[0];
            b = (i == 12) ? lt[15:8] : (i == 13) ? lt[7:0] : b;
            f = (i == n - 4) ? ~c ^ {31'h0, bad} : f;
            b = (i >= n - 4) ? f[8 * (i - n + 4) +: 8] : b;
            fb[i % 4] = (i < 4) ? b : fb[i % 4];
            c = c ^ {24'h0, b};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ rxsw_pkg::CRC_POLY_R : c >> 1;
            @(posedge pclk);
            rx_byte       <= b;
            rx_byte_valid <= 1'b1;
            rx_err        <= er && i == 20;
            rx_col        <= ca > 0 && i >= ca;
            @(posedge pclk);
            rx_byte_valid <= 1'b0;
            // released byte lane shows the inverse, never a stale value
            rx_byte       <= ~b;
        end
        @(posedge pclk);
        rx_frame        <= 1'b0;
        rx_err          <= 1'b0;
        rx_col          <= 1'b0;
        rx_dribble_bits <= db;
        rx_mode_10m     <= m10;
        @(posedge pclk);
        rx_dribble_bits <= ~db;
        rx_mode_10m     <= ~m10;
        repeat (4) @(posedge pclk);
    endtask
endmodule // rxsw_frame_src

/* rxsw_top_tb.sv */
// rxsw_top_tb: self-checking bench for rxsw_top
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module rxsw_top_tb;
    // apb master side
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, receiver_halted_irq;
    // frame path pins from the model
    logic        rx_frame, rx_byte_valid, rx_err, rx_col, rx_mode_10m;
    logic [7:0]  rx_byte;
    logic [2:0]  rx_dribble_bits;
    // notes {slverr, data, mask} and counters
    logic [64:0] expq [$];
    logic [64:0] nt;
    int          num_errors = 0;
    int          n_checks = 0;
    int          nirq = 0;
    int          cyc = 0;
    always #12.5 pclk = ~pclk;
    rxsw_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_frame, .rx_byte_valid, .rx_byte, .rx_err, .rx_col,
        .rx_dribble_bits, .rx_mode_10m, .receiver_halted_irq);
    rxsw_frame_src src (.pclk, .rx_frame, .rx_byte_valid, .rx_byte, .rx_err, .rx_col,
        .rx_dribble_bits, .rx_mode_10m);
    // one apb transfer; a read leaves its note first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e, input logic [31:0] m);
        if (!w)
            expq.push_back({e, m});
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF);
        apb(1'b0, a, 32'h0, e, m);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, 32'h0);
    endtask
    // send a frame, then pop its status; crc bit ignored for runt, late collision and watchdog frames
    task automatic frm(input int n, input logic mc, input logic [15:0] lt, input logic er,
                       input int ca, input logic [2:0] db, input logic m10, input logic bad);
        logic rn, lg, cl, wd, cr;
        rn = n < 64;
        lg = n > 1518;
        cl = ca >= 64;
        wd = n > 2048;
        cr = bad | er;
        src.send(n, mc, lt, er, ca, db, m10, bad);
        rd(8'h08, {3'b000, n[13:0], rn | lg | cl | cr, 3'b000, rn, mc, 2'b00, lg, cl,
           n >= 14 && lt > 16'd1500, wd, er, !cl && (m10 ? db >= 3 : db == 4), cr, 1'b0},
           (rn | cl | wd) ? 32'hFFFF_FFFD : 32'hFFFF_FFFF);
    endtask
    task automatic tend(input string s);
        $display("test done: %s", s);
    endtask
    task final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // watcher: halt pulses, and each read answer against the oldest note
    always @(posedge pclk)
    begin
        cyc++;
        if (receiver_halted_irq === 1'b1)
            nirq++;
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
        begin
            nt = expq.pop_front();
            `CHK({pslverr, prdata & nt[31:0]}, {nt[64], nt[63:32] & nt[31:0]})
        end
        // hang guard
        if (cyc == 40000)
        begin
            num_errors++;
            final_report();
        end
    end
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 33'h0);
        rd(8'h04, 33'h0);
        rd(8'h40, 33'h1_0000_0000, 32'h0);
        wr(8'h00, 32'h0001_0004);
        rd(8'h04, 33'h2, 32'h2);
        tend("reset and map");
        frm(64, 0, 16'h0800, 0, 0, 0, 0, 0);
        rd(8'h0C, {1'b0, src.fb[3], src.fb[2], src.fb[1], src.fb[0]});
        frm(60, 0, 16'h0800, 0, 0, 0, 0, 0);
        frm(80, 1, 16'h0040, 1, 0, 0, 0, 0);
        frm(70, 0, 16'h05DD, 0, 0, 0, 0, 1);
        frm(1519, 0, 16'h0800, 0, 0, 0, 0, 0);
        frm(100, 0, 16'h0800, 0, 90, 3'd4, 0, 0);
        frm(100, 0, 16'h0800, 0, 0, 3'd3, 1, 0);
        frm(100, 0, 16'h0800, 0, 0, 3'd3, 0, 0);
        frm(10, 0, 16'h0800, 0, 0, 0, 0, 0);
        frm(2100, 0, 16'h0800, 0, 0, 0, 0, 0);
        tend("status word");
        wr(8'h00, 32'h4);
        src.send(60, 0, 16'h0800, 0, 0, 0, 0, 0);
        rd(8'h04, 33'h2, 32'hF02);
        rd(8'h08, 33'h0);
        rd(8'h04, 33'h3, 32'h3);
        wr(8'h04, 32'h1);
        rd(8'h04, 33'h2, 32'h3);
        tend("runt drop and underrun");
        fork
            frm(200, 0, 16'h0800, 0, 0, 0, 0, 0);
            begin
                repeat (100) @(posedge pclk);
                wr(8'h00, 32'h0);
            end
        join
        repeat (10) @(posedge pclk);
        `CHK(nirq, 1)
        rd(8'h04, 33'h0, 32'h2);
        src.send(64, 0, 16'h0800, 0, 0, 0, 0, 0);
        wr(8'h00, 32'h4);
        repeat (9) src.send(64, 0, 16'h0800, 0, 0, 0, 0, 0);
        rd(8'h04, 33'h803, 32'hF03);
        tend("halt, resume and overrun");
        final_report();
    end
endmodule // rxsw_top_tb
